/* File: ebsc_params.svh */
// Offsets, reset values, field positions and widths for the external bus controller
`ifndef EBSC_PARAMS_SVH
`define EBSC_PARAMS_SVH
`define EBSC_OFS_BUS_CTRL1    32'hFF800000
`define EBSC_OFS_BUS_CTRL2    32'hFF800004
`define EBSC_OFS_WAIT_CTRL1   32'hFF800008
`define EBSC_OFS_WAIT_CTRL2   32'hFF80000C
`define EBSC_OFS_WAIT_CTRL3   32'hFF800010
`define EBSC_OFS_MEM_CTRL     32'hFF800014
`define EBSC_OFS_CARD_CTRL    32'hFF800018
`define EBSC_OFS_RFSH_CSR     32'hFF80001C
`define EBSC_OFS_RFSH_CNT     32'hFF800020
`define EBSC_OFS_RFSH_CONST   32'hFF800024
`define EBSC_OFS_RFSH_COUNT   32'hFF800028
`define EBSC_OFS_BUS_CTRL3    32'hFF800050
`define EBSC_OFS_BUS_CTRL4    32'hFE0A00F0
`define EBSC_OFS_AREA_TYPE    32'hFF800060
`define EBSC_OFS_STRAP_STAT   32'hFF800064
`define EBSC_SDMODE2_BASE     16'hFF90
`define EBSC_SDMODE3_BASE     16'hFF94
`define EBSC_RST_BUS_CTRL1    32'h00000000
`define EBSC_RST_BUS_CTRL2    32'h00003FFC
`define EBSC_RST_WAIT_CTRL1   32'h77777777
`define EBSC_RST_WAIT_CTRL2   32'hFFFEEFFF
`define EBSC_RST_WAIT_CTRL3   32'h07777777
`define EBSC_RST_MEM_CTRL     32'h00000000
`define EBSC_RST_CARD_CTRL    32'h00000000
`define EBSC_RST_RFSH         32'h00000000
`define EBSC_RST_BUS_CTRL3    32'h00000001
`define EBSC_RST_BUS_CTRL4    32'h00000000
`define EBSC_RST_AREA_TYPE    32'h00000000
`define EBSC_MASK_HALF        32'h0000FFFF
`define EBSC_CARD_MODE_BIT    0
`define EBSC_CKE_OFF_BIT      31
`define EBSC_IDX_AREA_TYPE    13
`define EBSC_IDX_STATUS       14
`define EBSC_NUM_REGS         14
`define EBSC_SYNC_W           39
`endif

/* File: ebsc_pkg.sv */
// Types for the external bus state controller
`include "ebsc_params.svh"
package ebsc_pkg;
  typedef enum logic [2:0] {
    IF_SRAM   = 3'h0,
    IF_BROM   = 3'h1,
    IF_MPX    = 3'h2,
    IF_DRAM   = 3'h3,
    IF_SDRAM  = 3'h4,
    IF_CARD   = 3'h5,
    IF_BCSRAM = 3'h6
  } ebsc_iface_type;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_ACCESS  = 3'h2,
    ST_MODESET = 3'h4
  } ebsc_fsm_type;
  typedef struct packed {
    ebsc_fsm_type                                fsm;
    logic [`EBSC_SYNC_W-1:0]                     sync1;
    logic [`EBSC_SYNC_W-1:0]                     sync2;
    logic [`EBSC_NUM_REGS-1:0][31:0]             regs;
    logic [1:0][7:0]                             sdram_mode;
    logic [1:0]                                  strap_width;
    logic                                        strap_sram;
    logic                                        strap_little;
    logic                                        strap_master;
    logic                                        grant;
    logic                                        own;
    logic [28:0]                                 addr;
    logic [31:0]                                 wdata;
    logic                                        write;
    logic [3:0]                                  be;
    logic [7:0]                                  beats;
    logic [7:0]                                  beat;
    logic                                        first;
    logic                                        card_attr;
    logic                                        card_io;
    logic [1:0]                                  dma;
    logic                                        mode_area3;
    logic [15:0]                                 mode_addr;
    logic [31:0]                                 prdata;
    logic                                        resp_valid;
    logic [31:0]                                 rdata;
  } ebsc_state_type;
endpackage

/* File: ebsc_top.sv */
// External bus state controller: pins, straps, bus release and register file
//
// Overview of operation
// R1: For SDRAM or multiplexed areas, cycle start pulses once per whole burst.
// R2: For other interface types, cycle start pulses in every burst data cycle.
// R3: Seven active-low area selects, only the accessed area asserted.
// R4: Area 5 and 6 selects double as the card first-byte enables.
// R5: Direction output shows read or write; also write indication for DRAM, SDRAM, card.
// R6: DRAM and SDRAM areas drive the row strobe.
// R7: Shared strobe marks reads; column strobe for SDRAM, frame for multiplexed.
// R8: SRAM areas get four per-byte write strobes, lane 0 to lane 3.
// R9: Card areas: lane strobes are attribute select, write, I/O read, I/O write.
// R10: DRAM areas drive one column strobe per byte lane.
// R11: SDRAM areas use the same four lane pins as byte masks.
// R12: The ready input extends the current bus cycle while it requests waits.
// R13: Reset samples area 0 interface pin: 1 SRAM, 0 multiplexed.
// R14: Card I/O width input honoured only in little-endian operation.
// R15: Clock-enable output drives the SDRAM clock enable.
// R16: Release request input and grant output; roles swap in slave mode.
// R17: Width pins sampled at reset as area 0 width, later card second enables.
// R18: Width pins are outputs only while the card-mode bit is 1.
// R19: Reset samples the endian pin.
// R20: Reset samples the master/slave pin.
// R21: Two data acknowledge outputs mark DMA channel 0 and 1 transfers.
// R22: Software sets SDRAM mode of area 2 or 3 by byte writes to a window.
// R23: Area 0 width code: 00 reserved, 01 8 bits, 10 16 bits, 11 32 bits.
// R24: Reset samples are held from reset release until the next reset.
`timescale 1ns/1ps
`default_nettype none
`include "ebsc_params.svh"

module ebsc_top #(
  parameter int unsigned BEAT_W = 4
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // APB register port
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Internal access requests
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [28:0]       req_addr,
  input  wire logic [3:0]        req_be,
  input  wire logic [31:0]       req_wdata,
  input  wire logic [BEAT_W-1:0] req_beats,
  input  wire logic              req_card_attr,
  input  wire logic              req_card_io,
  input  wire logic [1:0]        req_dma,
  output logic                   req_wdata_take,
  output logic                   resp_valid,
  output logic [31:0]            resp_rdata,
  // External bus
  output logic [25:0]            address_out,
  input  wire logic [31:0]       data_in,
  output logic [31:0]            data_out,
  output logic                   data_oe,
  output logic                   bus_drive_oe,
  output logic                   cycle_start_strobe_n,
  output logic [6:0]             area_selects_n,
  output logic                   rd_wr,
  output logic                   row_strobe_n,
  output logic                   read_colstrobe_frame_n,
  output logic                   lane0_write_attr_select_n,
  output logic                   lane1_write_strobe_n,
  output logic                   lane2_write_io_read_n,
  output logic                   lane3_write_io_write_n,
  output logic [3:0]             lane_column_mask_n,
  output logic                   clock_enable_out,
  output logic                   dma_ack_ch0_n,
  output logic                   dma_ack_ch1_n,
  // Handshake and dual-use pins
  input  wire logic              ext_ready_n,
  input  wire logic              area0_iface_io_width_n,
  input  wire logic              release_request_in_n,
  output logic                   bus_grant_out_n,
  input  wire logic              width_pin_low_card_enable_a_in,
  output logic                   width_pin_low_card_enable_a_out,
  output logic                   width_pin_low_card_enable_a_oe,
  input  wire logic              width_pin_high_card_enable_b_in,
  output logic                   width_pin_high_card_enable_b_out,
  output logic                   width_pin_high_card_enable_b_oe,
  input  wire logic              endian_mode_pin,
  input  wire logic              master_slave_pin
);

  ebsc_pkg::ebsc_state_type q;
  ebsc_pkg::ebsc_state_type d;
  ebsc_pkg::ebsc_iface_type cur_type;
  logic [2:0]  cur_area;
  logic [4:0]  rix;
  logic        run, active, mode_cyc, cur_write, card, burst_once, sram_like;
  logic        rdy_s, iow_s, breq_s, sdm_hit, acc, ce2, io16_ok, beat_done;
  logic [31:0] data_s, status;
  logic [3:0]  we_lane;

  function automatic logic [4:0] reg_index(input logic [31:0] a);
    case (a)
      `EBSC_OFS_BUS_CTRL1:  reg_index = 5'h10;
      `EBSC_OFS_BUS_CTRL2:  reg_index = 5'h11;
      `EBSC_OFS_WAIT_CTRL1: reg_index = 5'h12;
      `EBSC_OFS_WAIT_CTRL2: reg_index = 5'h13;
      `EBSC_OFS_WAIT_CTRL3: reg_index = 5'h14;
      `EBSC_OFS_MEM_CTRL:   reg_index = 5'h15;
      `EBSC_OFS_CARD_CTRL:  reg_index = 5'h16;
      `EBSC_OFS_RFSH_CSR:   reg_index = 5'h17;
      `EBSC_OFS_RFSH_CNT:   reg_index = 5'h18;
      `EBSC_OFS_RFSH_CONST: reg_index = 5'h19;
      `EBSC_OFS_RFSH_COUNT: reg_index = 5'h1A;
      `EBSC_OFS_BUS_CTRL3:  reg_index = 5'h1B;
      `EBSC_OFS_BUS_CTRL4:  reg_index = 5'h1C;
      `EBSC_OFS_AREA_TYPE:  reg_index = 5'h1D;
      `EBSC_OFS_STRAP_STAT: reg_index = 5'h1E;
      default:              reg_index = 5'h00;
    endcase
  endfunction

  // Half-word registers keep their upper bits at zero
  function automatic logic [31:0] reg_mask(input logic [3:0] i);
    case (i)
      4'h1, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB: reg_mask = `EBSC_MASK_HALF;
      default:                                 reg_mask = 32'hFFFFFFFF;
    endcase
  endfunction

  function automatic ebsc_pkg::ebsc_iface_type type_of(input logic [2:0] area, input logic [31:0] types,
                                                        input logic sram0);
    if (area == 3'h0)
      type_of = sram0 ? ebsc_pkg::IF_SRAM : ebsc_pkg::IF_MPX; // see R13
    else
      type_of = ebsc_pkg::ebsc_iface_type'(types[3*area +: 3]);
  endfunction

  function automatic logic [2:0] width_dec(input logic [1:0] code);
    case (code)
      2'h1:    width_dec = 3'h1;                                // see R23
      2'h2:    width_dec = 3'h2;
      2'h3:    width_dec = 3'h4;
      default: width_dec = 3'h0;
    endcase
  endfunction

  // Every pin input passes the two-stage synchroniser before use
  assign data_s   = q.sync2[38:7];
  assign rdy_s    = q.sync2[6];
  assign iow_s    = q.sync2[5];
  assign breq_s   = q.sync2[4];

  assign active   = q.fsm == ebsc_pkg::ST_ACCESS;
  assign mode_cyc = q.fsm == ebsc_pkg::ST_MODESET;
  assign run      = active | mode_cyc;
  assign cur_area = mode_cyc ? (q.mode_area3 ? 3'h3 : 3'h2) : q.addr[28:26];
  assign cur_type = mode_cyc ? ebsc_pkg::IF_SDRAM : type_of(q.addr[28:26], q.regs[`EBSC_IDX_AREA_TYPE],
                                                            q.strap_sram);
  assign cur_write  = mode_cyc | q.write;
  assign card       = cur_type == ebsc_pkg::IF_CARD;
  assign burst_once = cur_type == ebsc_pkg::IF_SDRAM || cur_type == ebsc_pkg::IF_MPX;
  assign sram_like  = !burst_once && !card && cur_type != ebsc_pkg::IF_DRAM;
  assign beat_done  = active && !rdy_s;                           // see R12
  assign io16_ok    = !q.card_io || (!iow_s && q.strap_little);    // see R14
  assign ce2        = active && card && (q.be[1] || q.be[3]) && io16_ok;

  assign status = {22'h0, q.grant, q.own, q.strap_master, q.strap_little, q.strap_sram,
                   width_dec(q.strap_width), q.strap_width};

  // APB decode; a mode-window write waits for the external mode cycle
  assign rix     = reg_index(paddr);
  assign sdm_hit = paddr[31:16] == `EBSC_SDMODE2_BASE || paddr[31:16] == `EBSC_SDMODE3_BASE;
  assign acc     = psel && penable;
  assign pready  = !(sdm_hit && pwrite) || mode_cyc;
  assign pslverr = acc && pready && !rix[4] && !sdm_hit;
  assign prdata  = q.prdata;

  assign req_ready      = q.fsm == ebsc_pkg::ST_IDLE && q.own && !(acc && sdm_hit && pwrite)
                          && !(q.strap_master && !breq_s);
  assign req_wdata_take = beat_done && q.write && q.beat != q.beats - 8'h1;
  assign resp_valid     = q.resp_valid;
  assign resp_rdata     = q.rdata;

  always_comb begin
    d            = q;
    d.sync1      = {data_in, ext_ready_n, area0_iface_io_width_n, release_request_in_n, endian_mode_pin,
                    master_slave_pin, width_pin_low_card_enable_a_in, width_pin_high_card_enable_b_in};
    d.sync2      = q.sync1;
    d.resp_valid = 1'b0;
    if (psel && !penable) begin
      if (rix[3:0] == 4'(`EBSC_IDX_STATUS))
        d.prdata = status;
      else if (rix[4])
        d.prdata = q.regs[rix[3:0]];
      else
        d.prdata = 32'h0;
    end
    if (acc && pwrite && rix[4] && rix[3:0] != 4'(`EBSC_IDX_STATUS))
      d.regs[rix[3:0]] = pwdata & reg_mask(rix[3:0]);
    // Bus release arbitration
    if (q.strap_master) begin
      if (q.fsm == ebsc_pkg::ST_IDLE && !q.grant && !breq_s)
        d.grant = 1'b1;                                           // see R16
      else if (q.grant && breq_s)
        d.grant = 1'b0;
      d.own = !d.grant;
    end else begin
      d.grant = req_valid || (acc && sdm_hit && pwrite) || q.fsm != ebsc_pkg::ST_IDLE;
      d.own   = !breq_s;                                          // see R16
    end
    case (q.fsm)
      ebsc_pkg::ST_IDLE: begin
        if (acc && sdm_hit && pwrite && q.own && !(q.strap_master && !breq_s)) begin
          d.fsm        = ebsc_pkg::ST_MODESET;                    // see R22
          d.mode_area3 = paddr[18];
          d.mode_addr  = paddr[15:0];
          d.sdram_mode[paddr[18]] = pwdata[7:0];
        end else if (req_valid && req_ready) begin
          d.fsm       = ebsc_pkg::ST_ACCESS;
          d.addr      = req_addr;
          d.write     = req_write;
          d.be        = req_be;
          d.wdata     = req_wdata;
          d.beats     = (req_beats == '0) ? 8'h1 : 8'(req_beats);
          d.beat      = 8'h0;
          d.first     = 1'b1;
          d.card_attr = req_card_attr;
          d.card_io   = req_card_io;
          d.dma       = req_dma;
        end
      end
      ebsc_pkg::ST_ACCESS: begin
        if (beat_done) begin
          d.resp_valid = 1'b1;
          d.rdata      = q.write ? 32'h0 : data_s;
          d.first      = 1'b1;
          if (q.beat == q.beats - 8'h1) begin
            d.fsm = ebsc_pkg::ST_IDLE;
          end else begin
            d.beat = q.beat + 8'h1;
            d.addr = q.addr + 29'h4;
            if (q.write)
              d.wdata = req_wdata;
          end
        end else begin
          d.first = 1'b0;                                         // see R12
        end
      end
      ebsc_pkg::ST_MODESET: d.fsm = ebsc_pkg::ST_IDLE;
      default:              d.fsm = ebsc_pkg::ST_IDLE;
    endcase
    // Synchronous reset; straps follow the pins until release, then freeze
    if (srst) begin
      d                = '0;
      d.sync1          = {data_in, ext_ready_n, area0_iface_io_width_n, release_request_in_n,
                          endian_mode_pin, master_slave_pin, width_pin_low_card_enable_a_in,
                          width_pin_high_card_enable_b_in};
      d.sync2          = q.sync1;
      d.fsm            = ebsc_pkg::ST_IDLE;
      d.strap_width    = {q.sync2[0], q.sync2[1]};                // see R17
      d.strap_sram     = q.sync2[5];                              // see R13
      d.strap_little   = q.sync2[3];                              // see R19
      d.strap_master   = q.sync2[2];                              // see R20
      d.own            = q.sync2[2];
      d.regs[0]        = `EBSC_RST_BUS_CTRL1;
      d.regs[1]        = `EBSC_RST_BUS_CTRL2;
      d.regs[2]        = `EBSC_RST_WAIT_CTRL1;
      d.regs[3]        = `EBSC_RST_WAIT_CTRL2;
      d.regs[4]        = `EBSC_RST_WAIT_CTRL3;
      d.regs[5]        = `EBSC_RST_MEM_CTRL;
      d.regs[6]        = `EBSC_RST_CARD_CTRL;
      d.regs[7]        = `EBSC_RST_RFSH;
      d.regs[8]        = `EBSC_RST_RFSH;
      d.regs[9]        = `EBSC_RST_RFSH;
      d.regs[10]       = `EBSC_RST_RFSH;
      d.regs[11]       = `EBSC_RST_BUS_CTRL3;
      d.regs[12]       = `EBSC_RST_BUS_CTRL4;
      d.regs[13]       = `EBSC_RST_AREA_TYPE;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  // Pin drivers
  generate
    for (genvar i = 0; i < 7; i++) begin : g_sel
      // Area 5 and 6 selects are also the card first-byte enables
      assign area_selects_n[i] = !(run && cur_area == 3'(i)); // see R3 see R4
    end
  endgenerate

  always_comb begin
    we_lane = 4'hF;
    if (active && card) begin
      we_lane[0] = !q.card_attr;                                  // see R9
      we_lane[1] = !(q.write && !q.card_io);
      we_lane[2] = !(!q.write && q.card_io);
      we_lane[3] = !(q.write && q.card_io);
    end else if (active && q.write && sram_like) begin
      we_lane = ~q.be;                                            // see R8
    end
  end

  assign lane0_write_attr_select_n = we_lane[0];
  assign lane1_write_strobe_n      = we_lane[1];
  assign lane2_write_io_read_n     = we_lane[2];
  assign lane3_write_io_write_n    = we_lane[3];

  // Same pins: column strobes for DRAM, byte masks for SDRAM
  assign lane_column_mask_n = (run && (cur_type == ebsc_pkg::IF_DRAM || cur_type == ebsc_pkg::IF_SDRAM))
                              ? ~q.be : 4'hF;                     // see R10 see R11
  assign cycle_start_strobe_n = !(active && q.first && (!burst_once || q.beat == 8'h0)); // see R1 see R2
  assign rd_wr        = !(run && cur_write);                      // see R5
  assign row_strobe_n = !(run && (cur_type == ebsc_pkg::IF_DRAM || cur_type == ebsc_pkg::IF_SDRAM)); // see R6
  assign read_colstrobe_frame_n = !(run && (burst_once || (!cur_write && !(card && q.card_io)))); // see R7
  assign address_out  = mode_cyc ? {10'h0, q.mode_addr} : q.addr[25:0];
  assign data_out     = q.wdata;
  assign data_oe      = active && q.write && q.own;
  assign bus_drive_oe = q.own;
  assign bus_grant_out_n  = !q.grant;
  assign clock_enable_out = !q.regs[`EBSC_IDX_AREA_TYPE][`EBSC_CKE_OFF_BIT]; // see R15
  assign dma_ack_ch0_n    = !(active && q.dma[0]);                // see R21
  assign dma_ack_ch1_n    = !(active && q.dma[1]);
  // Width pins turn into second-byte card enables only in card mode
  assign width_pin_low_card_enable_a_oe   = q.regs[0][`EBSC_CARD_MODE_BIT]; // see R18
  assign width_pin_high_card_enable_b_oe  = q.regs[0][`EBSC_CARD_MODE_BIT];
  assign width_pin_low_card_enable_a_out  = !(ce2 && cur_area == 3'h5);     // see R17
  assign width_pin_high_card_enable_b_out = !(ce2 && cur_area == 3'h6);

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_one_area_select: assert property ($onehot0(~area_selects_n)) // see R3
    else $error("more than one area select active");
  a_bs_burst_once: assert property (active && burst_once && q.beat != 8'h0 |-> cycle_start_strobe_n) // see R1
    else $error("cycle start repeated inside a single-start burst");
  a_bs_each_beat: assert property (active && !burst_once && beat_done && q.beat != q.beats - 8'h1
                                   |=> !cycle_start_strobe_n) // see R2
    else $error("cycle start missing on a burst beat");
  a_wait_extends: assert property (active && rdy_s |=> active && $stable(q.beat) && cycle_start_strobe_n) // see R12
    else $error("bus cycle ended while wait was requested");
  a_strap_hold: assert property (!$past(srst) |-> $stable({q.strap_width, q.strap_sram, q.strap_little,
                                                          q.strap_master})) // see R24
    else $error("power-on samples changed after reset release");
  a_width_pin_dir: assert property ($rose(q.regs[0][`EBSC_CARD_MODE_BIT]) |-> width_pin_low_card_enable_a_oe
                                    && width_pin_high_card_enable_b_oe) // see R18
    else $error("width pins not driven in card mode");
  a_row_strobe: assert property (!row_strobe_n |-> cur_type inside {ebsc_pkg::IF_DRAM, ebsc_pkg::IF_SDRAM}) // see R6
    else $error("row strobe outside DRAM or SDRAM area");
  a_dir_on_write: assert property (data_oe |-> !rd_wr && !area_selects_n[cur_area]) // see R5
    else $error("data driven without write direction");
  a_card_strobes: assert property (active && card && q.write && q.card_io |-> !lane3_write_io_write_n
                                   && lane2_write_io_read_n && lane1_write_strobe_n) // see R9
    else $error("wrong card I/O write strobes");
  a_mode_cycle: assert property (q.fsm == ebsc_pkg::ST_IDLE && acc && sdm_hit && pwrite && q.own && breq_s
                                 |=> mode_cyc && !row_strobe_n && !read_colstrobe_frame_n && !rd_wr ##1
                                 q.fsm == ebsc_pkg::ST_IDLE) // see R22
    else $error("mode register write cycle malformed");
  c_sdram_burst: cover property (active && cur_type == ebsc_pkg::IF_SDRAM && q.beat == 8'h1);
  c_wait_states: cover property (active && rdy_s [*3] ##1 beat_done);
  c_bus_release: cover property (!bus_grant_out_n && !bus_drive_oe);
  c_card_access: cover property (active && card && ce2);

endmodule // ebsc_top
`default_nettype wire

/* File: ebsc_mem_model.sv */
// Far-side memory model: answers a selected cycle after a set number of wait cycles
`timescale 1ns/1ps
`default_nettype none
module ebsc_mem_model (
  // Clock and wait setting
  input  wire logic        clock,
  input  wire logic [3:0]  waits,
  // Bus from the controller
  input  wire logic [6:0]  area_selects_n,
  input  wire logic        rd_wr,
  // Answer to the controller
  output logic             ext_ready_n,
  output logic [31:0]      data_in
);
  logic [3:0] cnt = 4'h0;
  always @(posedge clock) begin
    cnt <= (&area_selects_n) ? 4'h0 : cnt + 4'h1;
  end
  // Holds off ready while counting, so slow answers stretch the cycle
  assign ext_ready_n = (&area_selects_n) || (cnt < waits);
  // Unselected: 55555555 once the count has cleared; written: toggling pattern; never a stale value
  assign data_in = (&area_selects_n || !rd_wr) ? {16{cnt[0], ~cnt[0]}} : 32'hA5A50F0F;
endmodule // ebsc_mem_model
`default_nettype wire

/* File: tb.sv */
// Testbench for the external bus controller: registers, straps and an SRAM write
`timescale 1ns/1ps
`default_nettype none
`include "ebsc_params.svh"
module tb;
  logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, req_wdata = 0, resp_rdata, data_in, data_out;
  logic req_valid = 0, req_ready, req_write = 0, req_card_attr = 0, req_card_io = 0, req_wdata_take, resp_valid;
  logic [28:0] req_addr = 0;
  logic [3:0] req_be = 0, req_beats = 4'h1, waits = 4'h3, lane_column_mask_n;
  logic [1:0] req_dma = 0;
  logic [25:0] address_out;
  logic [6:0] area_selects_n;
  logic data_oe, bus_drive_oe, cycle_start_strobe_n, rd_wr, row_strobe_n, read_colstrobe_frame_n;
  logic lane0_write_attr_select_n, lane1_write_strobe_n, lane2_write_io_read_n, lane3_write_io_write_n;
  logic clock_enable_out, dma_ack_ch0_n, dma_ack_ch1_n, ext_ready_n, bus_grant_out_n;
  logic area0_iface_io_width_n = 1, release_request_in_n = 1, endian_mode_pin = 1, master_slave_pin = 1;
  logic width_pin_low_card_enable_a_in = 0, width_pin_low_card_enable_a_out, width_pin_low_card_enable_a_oe;
  logic width_pin_high_card_enable_b_in = 1, width_pin_high_card_enable_b_out, width_pin_high_card_enable_b_oe;
  int error_cnt = 0, n_tests = 0;
  logic [31:0] ra [13] = '{`EBSC_OFS_BUS_CTRL1, `EBSC_OFS_BUS_CTRL2, `EBSC_OFS_WAIT_CTRL1, `EBSC_OFS_WAIT_CTRL2,
    `EBSC_OFS_WAIT_CTRL3, `EBSC_OFS_MEM_CTRL, `EBSC_OFS_CARD_CTRL, `EBSC_OFS_RFSH_CSR, `EBSC_OFS_RFSH_CNT,
    `EBSC_OFS_RFSH_CONST, `EBSC_OFS_RFSH_COUNT, `EBSC_OFS_BUS_CTRL3, `EBSC_OFS_BUS_CTRL4};
  logic [31:0] rv [13] = '{32'h0, 32'h00003FFC, 32'h77777777, 32'hFFFEEFFF, 32'h07777777, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h00000001, 32'h0};
  ebsc_top dut (.*);
  ebsc_mem_model mem (.clock(clock), .waits(waits), .area_selects_n(area_selects_n), .rd_wr(rd_wr),
    .ext_ready_n(ext_ready_n), .data_in(data_in));
  always #5 clock = ~clock;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held from setup until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clock);
    // Straps change after release; the frozen samples must not follow
    srst <= 0; width_pin_low_card_enable_a_in <= 1; endian_mode_pin <= 0;
    repeat (4) @(posedge clock);
    apb(0, `EBSC_OFS_STRAP_STAT, 0);
    chk("strap_status", 32'hEA, {24'h0, rd[7:0]});
    chk("pins_idle", 32'h7, {29'h0, clock_enable_out, bus_drive_oe, bus_grant_out_n});
    for (int i = 0; i < 13; i++) begin
      apb(0, ra[i], 0);
      chk("reset_value", rv[i], rd);
    end
    apb(1, `EBSC_OFS_BUS_CTRL2, 32'hFFFFFFFF);
    apb(0, `EBSC_OFS_BUS_CTRL2, 0);
    chk("half_mask", 32'h0000FFFF, rd);
    apb(0, 32'hFF800040, 0);
    chk("unmapped_err", 1, {31'h0, err});
    chk("width_oe_off", 0, {30'h0, width_pin_high_card_enable_b_oe, width_pin_low_card_enable_a_oe});
    apb(1, `EBSC_OFS_BUS_CTRL1, 32'h1);
    @(posedge clock);
    chk("width_oe_on", 3, {30'h0, width_pin_high_card_enable_b_oe, width_pin_low_card_enable_a_oe});
    // Mode write to area 2; its bus cycle is looked at mid-cycle, while pready is high for the mode cycle
    fork
      apb(1, 32'hFF900230, 32'h0000005A);
      begin
        @(posedge clock iff (psel && penable));
        @(negedge clock);
        chk("mode_cycle", 32'h7B, {22'h0, rd_wr, row_strobe_n, read_colstrobe_frame_n, area_selects_n});
        chk("mode_addr", 32'h230, {6'h0, address_out});
      end
    join
    // Area 1 SRAM two-beat write for DMA channel 0, lanes 0 and 2, slow far side
    req_valid <= 1; req_write <= 1; req_addr <= {3'h1, 26'h10}; req_be <= 4'h5; req_wdata <= 32'h11223344;
    req_beats <= 4'h2; req_dma <= 2'h1;
    @(posedge clock);
    while (req_ready !== 1'b1) @(posedge clock);
    req_valid <= 0;
    @(negedge clock);
    chk("area_sel", 32'h7D, {25'h0, area_selects_n});
    chk("lane_we", 32'hA, {28'h0, lane3_write_io_write_n, lane2_write_io_read_n, lane1_write_strobe_n,
      lane0_write_attr_select_n});
    chk("dir_cs", 0, {30'h0, rd_wr, cycle_start_strobe_n});
    chk("bus_out", 32'h14000010, {3'h0, dma_ack_ch1_n, dma_ack_ch0_n, data_oe, address_out});
    chk("data_out", 32'h11223344, data_out);
    // One response per beat; writes hand back zero data
    for (int b = 0; b < 2; b++) begin
      @(posedge clock);
      while (resp_valid !== 1'b1) @(posedge clock);
      chk("resp", 0, resp_rdata);
    end
    // An outside master asks for the bus once the controller is idle
    release_request_in_n <= 0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk("released", 0, {30'h0, bus_grant_out_n, bus_drive_oe});
    complete_run;
  end
endmodule // tb
`default_nettype wire
